// [logic/twu_pkg.sv]
// What this block does
// - sixteen-bit down-counter behind loadable eight-bit prescaler
// - clocked by count pin or core clock/4
// - run bit starts/stops, resumes held value
// - running constant loads at eoc, prescaler immediately
// - end of count on an enable with counter and prescaler both zero
// - single mode stops, reloads, clears run bit
// - continuous mode reloads and keeps counting
// - mode bit writable anytime, with run bit
// - input enable selects pin or clock/4
// - event mode counts falling edges after start
// - gated mode counts while pin high
// - triggerable mode starts on falling edge after run
// - retriggerable mode reloads on each falling edge
// - output disabled drives pin high
// - square wave toggles at each eoc
// - pwm mode copies level bit at eoc
// - select pin low at external reset forces watchdog, constant FFFFh
// - clearing enable bit enters watchdog, sticky
// - watchdog uses clock/4, constant locked, prescaler writable
// - watchdog eoc resets whole system
// - AAh then 55h to low register refreshes
// - watchdog ignores halt, run, mode bits
// - timer mode eoc raises interrupt request
package twu_pkg;
  // register offsets
  localparam logic [2:0] TWU_OFF_HIGH = 3'h0;
  localparam logic [2:0] TWU_OFF_LOW = 3'h1;
  localparam logic [2:0] TWU_OFF_PRESC = 3'h2;
  localparam logic [2:0] TWU_OFF_CTRL = 3'h3;
  localparam logic [2:0] TWU_OFF_WAIT = 3'h4;
  localparam logic [2:0] TWU_OFF_STATUS = 3'h5;
  // control field positions
  localparam int TWU_B_RUN = 7;
  localparam int TWU_B_SINGLE = 6;
  localparam int TWU_B_MD1 = 5;
  localparam int TWU_B_MD2 = 4;
  localparam int TWU_B_INPUT_ENABLE_BIT = 3;
  localparam int TWU_B_OUTPUT_MODE_BIT = 2;
  localparam int TWU_B_LEVEL = 1;
  localparam int TWU_B_OUTPUT_ENABLE_BIT = 0;
  localparam int TWU_B_WDEN_N = 6;
  // reset values
  localparam logic [7:0] TWU_RST_CNT = 8'hff;
  localparam logic [7:0] TWU_RST_PRESC = 8'hff;
  localparam logic [7:0] TWU_RST_CTRL = 8'h12;
  localparam logic [7:0] TWU_RST_WAIT = 8'h7f;
  localparam logic [15:0] TWU_HW_CONST = 16'hffff;
  // refresh key
  localparam logic [7:0] TWU_KEY_ARM = 8'haa;
  localparam logic [7:0] TWU_KEY_FIRE = 8'h55;
  // core clock divider
  localparam int TWU_DIV = 4;
  typedef enum logic [1:0] {
    TWU_MD_EVENT = 2'b00,
    TWU_MD_GATED = 2'b01,
    TWU_MD_TRIG = 2'b10,
    TWU_MD_RETRIG = 2'b11
  } twu_mode_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } twu_req_t;
endpackage

// [logic/twu_top.sv]
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module twu_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // register port
  input wire twu_pkg::twu_req_t i_req,
  output logic [7:0] o_rdata,
  // pins
  input wire logic i_count_input_pin,
  input wire logic i_hw_watchdog_select_pin,
  input wire logic i_ext_reset,
  input wire logic i_halt,
  output logic o_wave_output_pin,
  // system
  output logic o_irq,
  output logic o_system_reset
);
  import twu_pkg::*;

  logic [15:0] const_r, cnt_r;
  logic [7:0] presc_r, pcnt_r, ctrl_r;
  logic [1:0] div_r;
  logic [2:0] pin_sync_r;
  logic wden_n_r, hwsel_r, hw_wd_r, arm_r, armed_r, new_const_r, started_r, trig_r;
  logic hwsel_meta_r, ext_meta_r, ext_r;
  logic wave_r, fall, tick4, wd_mode, run, cnt_en, eoc, wr_ctrl, refresh, low_wr;
  twu_mode_t mode;

  // pin synchronisers, third stage feeds edge detect and gated mode
  // strap and external reset are pins too, so they get two flops as well
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pin_sync_r <= 3'h7;
      hwsel_meta_r <= 1'b1;
      hwsel_r <= 1'b1;
      ext_meta_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], i_count_input_pin};
      hwsel_meta_r <= i_hw_watchdog_select_pin;
      hwsel_r <= hwsel_meta_r;
      ext_meta_r <= i_ext_reset;
      ext_r <= ext_meta_r;
    end
  end
  assign fall = pin_sync_r[2] & ~pin_sync_r[1];

  // hardware watchdog strap caught on external reset only
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      hw_wd_r <= 1'b0;
    end else if (ext_r) begin
      hw_wd_r <= ~hwsel_r;
    end
  end

  assign wd_mode = hw_wd_r | ~wden_n_r;
  assign mode = twu_mode_t'(ctrl_r[TWU_B_MD1:TWU_B_MD2]);
  assign run = ctrl_r[TWU_B_RUN];
  assign wr_ctrl = i_req.wr && i_req.addr == TWU_OFF_CTRL;
  assign low_wr = i_req.wr && i_req.addr == TWU_OFF_LOW;

  // core clock / 4 enable
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign tick4 = div_r == 2'(TWU_DIV - 1);

  // trigger/event start gating
  always_ff @(posedge i_clock) begin
    if (i_reset || !run) begin
      trig_r <= 1'b0;
    end else if (fall) begin
      trig_r <= 1'b1;
    end
  end

  // prescaler input selection per mode
  always_comb begin
    cnt_en = 1'b0;
    if (wd_mode) begin
      cnt_en = tick4;
    end else if (run) begin
      if (ctrl_r[TWU_B_INPUT_ENABLE_BIT]) begin
        case (mode)
          TWU_MD_EVENT: cnt_en = fall & trig_r;
          TWU_MD_GATED: cnt_en = tick4 & pin_sync_r[2];
          TWU_MD_TRIG: cnt_en = tick4 & trig_r;
          TWU_MD_RETRIG: cnt_en = tick4;
          default: cnt_en = 1'b0;
        endcase
      end else begin
        cnt_en = tick4;
      end
    end
  end

  assign eoc = cnt_en && pcnt_r == 8'h0 && cnt_r == 16'h0;
  assign refresh = wd_mode && armed_r && i_req.wr && i_req.addr == TWU_OFF_LOW &&
    i_req.wdata == TWU_KEY_FIRE;

  // refresh detector
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      armed_r <= 1'b0;
    end else if (i_req.wr && i_req.addr == TWU_OFF_LOW) begin
      armed_r <= i_req.wdata == TWU_KEY_ARM;
    end
  end

  // constant, prescaler and wait register writes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      const_r <= {TWU_RST_CNT, TWU_RST_CNT};
      presc_r <= TWU_RST_PRESC;
      wden_n_r <= TWU_RST_WAIT[TWU_B_WDEN_N];
      new_const_r <= 1'b0;
    end else begin
      if (i_req.wr) begin
        case (i_req.addr)
          TWU_OFF_HIGH: if (!wd_mode) const_r[15:8] <= i_req.wdata;
          TWU_OFF_LOW: if (!wd_mode) const_r[7:0] <= i_req.wdata;
          TWU_OFF_PRESC: presc_r <= i_req.wdata;
          TWU_OFF_WAIT: if (!i_req.wdata[TWU_B_WDEN_N] && !hw_wd_r) wden_n_r <= 1'b0;
          default: ;
        endcase
      end
      if (hw_wd_r) begin
        const_r <= TWU_HW_CONST;
      end
      // set wins over the clear of the pending-constant flag
      if (i_req.wr && !wd_mode && (i_req.addr == TWU_OFF_HIGH || i_req.addr == TWU_OFF_LOW)) begin
        new_const_r <= 1'b1;
      end else if (eoc || (run && !started_r)) begin
        new_const_r <= 1'b0;
      end
    end
  end

  // control register with run clear on single eoc
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_r <= TWU_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= i_req.wdata;
    end else if (eoc && !wd_mode && ctrl_r[TWU_B_SINGLE]) begin
      ctrl_r[TWU_B_RUN] <= 1'b0;
    end
  end

  // counter and prescaler
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_r <= {TWU_RST_CNT, TWU_RST_CNT};
      pcnt_r <= TWU_RST_PRESC;
      started_r <= 1'b0;
    end else begin
      started_r <= run | wd_mode;
      if (refresh) begin
        cnt_r <= const_r;
        pcnt_r <= presc_r;
      end else if (!wd_mode && run && !started_r && new_const_r) begin
        cnt_r <= const_r;
        pcnt_r <= presc_r;
      end else if (!wd_mode && run && mode == TWU_MD_RETRIG && ctrl_r[TWU_B_INPUT_ENABLE_BIT] && fall) begin
        cnt_r <= const_r;
        pcnt_r <= presc_r;
      end else if (eoc) begin
        cnt_r <= const_r;
        pcnt_r <= presc_r;
      end else if (cnt_en) begin
        if (pcnt_r == 8'h0) begin
          pcnt_r <= presc_r;
          cnt_r <= cnt_r - 16'h1;
        end else begin
          pcnt_r <= pcnt_r - 8'h1;
        end
      end
    end
  end

  // waveform output
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wave_r <= 1'b1;
    end else if (!ctrl_r[TWU_B_OUTPUT_ENABLE_BIT]) begin
      wave_r <= 1'b1;
    end else if (eoc) begin
      wave_r <= ctrl_r[TWU_B_OUTPUT_MODE_BIT] ? ctrl_r[TWU_B_LEVEL] : ~wave_r;
    end
  end
  assign o_wave_output_pin = wave_r;

  // interrupt and system reset pulses; halt input has no effect here
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_irq <= 1'b0;
      o_system_reset <= 1'b0;
    end else begin
      o_irq <= eoc & ~wd_mode;
      o_system_reset <= eoc & wd_mode;
    end
  end

  // read data, one cycle after strobe
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= 8'h0;
    end else if (i_req.rd) begin
      case (i_req.addr)
        TWU_OFF_HIGH: o_rdata <= cnt_r[15:8];
        TWU_OFF_LOW: o_rdata <= cnt_r[7:0];
        TWU_OFF_PRESC: o_rdata <= presc_r;
        TWU_OFF_CTRL: o_rdata <= ctrl_r;
        TWU_OFF_WAIT: o_rdata <= {1'b0, wden_n_r, 6'h3f};
        TWU_OFF_STATUS: o_rdata <= {6'h0, hw_wd_r, wd_mode};
        default: o_rdata <= 8'h0;
      endcase
    end else begin
      o_rdata <= 8'h0;
    end
  end

  logic unused_halt;
  assign unused_halt = i_halt;

  // assertions
  // key writes on the low register, the steps of a refresh
  sequence s_key_arm;
    low_wr && i_req.wdata == TWU_KEY_ARM;
  endsequence
  sequence s_key_fire;
    low_wr && i_req.wdata == TWU_KEY_FIRE;
  endsequence
  sequence s_key_other;
    low_wr && i_req.wdata != TWU_KEY_ARM;
  endsequence

  // no timer interrupt while the watchdog owns the counter
  a_wd_no_irq: assert property (@(posedge i_clock) disable iff (i_reset)
    wd_mode |=> !o_irq)
    else $error("irq in watchdog mode");

  // watchdog end of count must reset the system
  a_eoc_sysreset: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && wd_mode) |=> o_system_reset)
    else $error("missing system reset");

  // single mode drops the run bit unless software rewrites it
  a_single_stop: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && !wd_mode && ctrl_r[TWU_B_SINGLE] && !wr_ctrl) |=> !run)
    else $error("single mode kept running");

  // disabled output parks high so the pin can be shared
  a_output_enable_bit_high: assert property (@(posedge i_clock) disable iff (i_reset)
    !ctrl_r[TWU_B_OUTPUT_ENABLE_BIT] |=> o_wave_output_pin)
    else $error("disabled output low");

  // software can never leave watchdog mode
  a_wd_sticky: assert property (@(posedge i_clock) disable iff (i_reset)
    !wden_n_r |=> !wden_n_r)
    else $error("watchdog enable reverted");

  // refresh reloads the counter in the next cycle
  a_refresh_load: assert property (@(posedge i_clock) disable iff (i_reset)
    refresh |=> cnt_r == const_r)
    else $error("refresh did not reload");

  // stopped timer sees no enables
  a_stop_hold: assert property (@(posedge i_clock) disable iff (i_reset)
    (!run && !wd_mode) |-> !cnt_en)
    else $error("counting while stopped");

  // hardware watchdog pins the constant
  a_hw_const: assert property (@(posedge i_clock) disable iff (i_reset)
    hw_wd_r |=> const_r == TWU_HW_CONST)
    else $error("hw constant changed");

  // hardware watchdog flag only clears on reset
  a_hw_latched: assert property (@(posedge i_clock) disable iff (i_reset)
    hw_wd_r |=> hw_wd_r)
    else $error("hw watchdog flag dropped");

  // first key arms the detector
  a_key_arm: assert property (@(posedge i_clock) disable iff (i_reset)
    s_key_arm |=> armed_r)
    else $error("refresh detector not armed");

  // any other low write disarms it
  a_key_disarm: assert property (@(posedge i_clock) disable iff (i_reset)
    s_key_other |=> !armed_r)
    else $error("refresh detector stayed armed");

  // second key while armed reloads counter and prescaler
  a_key_reload: assert property (@(posedge i_clock) disable iff (i_reset)
    (wd_mode && armed_r) ##0 s_key_fire |=> cnt_r == $past(const_r) && pcnt_r == $past(presc_r))
    else $error("key pair did not reload");

  // interrupt is a single-cycle pulse
  a_irq_pulse: assert property (@(posedge i_clock) disable iff (i_reset)
    o_irq |=> !o_irq)
    else $error("irq longer than one cycle");

  // system reset is a single-cycle pulse
  a_sysrst_pulse: assert property (@(posedge i_clock) disable iff (i_reset)
    o_system_reset |=> !o_system_reset)
    else $error("system reset longer than one cycle");

  // timer end of count raises the interrupt
  a_eoc_irq: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && !wd_mode) |=> o_irq)
    else $error("missing timer irq");

  // timer mode never resets the system
  a_timer_no_sysrst: assert property (@(posedge i_clock) disable iff (i_reset)
    !wd_mode |=> !o_system_reset)
    else $error("system reset in timer mode");

  // running timer reloads its constant at end of count
  a_cont_reload: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && !wd_mode && started_r && !fall) |=> cnt_r == $past(const_r))
    else $error("no reload at end of count");

  // watchdog keeps counting after end of count
  a_wd_reload: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && wd_mode && !refresh) |=> cnt_r == $past(const_r))
    else $error("watchdog did not reload");

  // clock/4 enable recurs every fourth cycle
  a_tick_period: assert property (@(posedge i_clock) disable iff (i_reset)
    tick4 |-> ##4 tick4)
    else $error("clock/4 enable off period");

  // prescaler steps down on each enable
  a_presc_step: assert property (@(posedge i_clock) disable iff (i_reset)
    (cnt_en && pcnt_r != 8'h0 && !refresh && !fall && (started_r || wd_mode))
    |=> pcnt_r == $past(pcnt_r) - 8'h1)
    else $error("prescaler did not step");

  // counter steps down when the prescaler wraps
  a_cnt_step: assert property (@(posedge i_clock) disable iff (i_reset)
    (cnt_en && pcnt_r == 8'h0 && cnt_r != 16'h0 && !refresh && !fall && (started_r || wd_mode))
    |=> cnt_r == $past(cnt_r) - 16'h1)
    else $error("counter did not step");

  // no enable, no load: counter keeps its value
  a_cnt_hold: assert property (@(posedge i_clock) disable iff (i_reset)
    (!cnt_en && !refresh && !fall && (started_r || !run || wd_mode)) |=> $stable(cnt_r))
    else $error("counter moved without enable");

  // gated mode holds while the pin is low
  a_gate_low: assert property (@(posedge i_clock) disable iff (i_reset)
    (!wd_mode && run && ctrl_r[TWU_B_INPUT_ENABLE_BIT] && mode == TWU_MD_GATED && !pin_sync_r[2])
    |-> !cnt_en)
    else $error("gated count with pin low");

  // triggerable mode waits for its edge
  a_trig_wait: assert property (@(posedge i_clock) disable iff (i_reset)
    (!wd_mode && run && ctrl_r[TWU_B_INPUT_ENABLE_BIT] && mode == TWU_MD_TRIG && !trig_r) |-> !cnt_en)
    else $error("triggered count before edge");

  // retriggerable mode reloads on each falling edge
  a_retrig_load: assert property (@(posedge i_clock) disable iff (i_reset)
    (!wd_mode && run && ctrl_r[TWU_B_INPUT_ENABLE_BIT] && mode == TWU_MD_RETRIG && fall)
    |=> cnt_r == $past(const_r))
    else $error("edge did not reload");

  // square wave flips at every end of count
  a_wave_toggle: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && ctrl_r[TWU_B_OUTPUT_ENABLE_BIT] && !ctrl_r[TWU_B_OUTPUT_MODE_BIT])
    |=> o_wave_output_pin != $past(o_wave_output_pin))
    else $error("square wave did not toggle");

  // pwm mode copies the level bit at end of count
  a_wave_pwm: assert property (@(posedge i_clock) disable iff (i_reset)
    (eoc && ctrl_r[TWU_B_OUTPUT_ENABLE_BIT] && ctrl_r[TWU_B_OUTPUT_MODE_BIT])
    |=> o_wave_output_pin == $past(ctrl_r[TWU_B_LEVEL]))
    else $error("pwm level not copied");

  // enabled output only moves at end of count
  a_wave_hold: assert property (@(posedge i_clock) disable iff (i_reset)
    (!eoc && ctrl_r[TWU_B_OUTPUT_ENABLE_BIT]) |=> $stable(o_wave_output_pin))
    else $error("output moved between ends of count");

  // constant is locked once the watchdog runs
  a_const_locked: assert property (@(posedge i_clock) disable iff (i_reset)
    (wd_mode && !hw_wd_r && i_req.wr &&
    (i_req.addr == TWU_OFF_HIGH || i_req.addr == TWU_OFF_LOW)) |=> $stable(const_r))
    else $error("constant written in watchdog mode");

  // prescaler writes land at once, in any mode
  a_presc_live: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_req.wr && i_req.addr == TWU_OFF_PRESC) |=> presc_r == $past(i_req.wdata))
    else $error("prescaler write lost");
endmodule // twu_top

// [dv/twu_pin_model.sv]
`timescale 1ns/1ps
module twu_pin_model (
  // clock and control
  input wire logic i_clock,
  input wire logic i_run,
  // pins
  input wire logic i_wave,
  output logic o_pin,
  output logic [7:0] o_flips
);
  logic [2:0] phase_r = 3'h0;
  logic wave_r = 1'b1;
  // idle high; falling edges exactly 8 clocks apart, never closer
  always_ff @(posedge i_clock) begin
    phase_r <= i_run ? phase_r + 3'h1 : 3'h0;
    o_pin <= ~i_run | ~phase_r[2];
  end
  // count level changes on the output pin; unknowns are not counted
  initial o_flips = 8'h00;
  always @(posedge i_clock) begin
    wave_r <= i_wave;
    if ((i_wave ^ wave_r) === 1'b1) begin
      o_flips <= o_flips + 8'h01;
    end
  end
endmodule // twu_pin_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import twu_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  twu_req_t req = '0;
  logic pin_run = 1'b0;
  logic strap = 1'b1;
  logic ext_rst = 1'b0;
  logic [7:0] rdata, flips, f0;
  logic pin, wave, irq, sysrst;
  logic [31:0] lf = 32'h29a0b088;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  // 40 MHz core clock
  always #12.5 i_clock = ~i_clock;
  twu_top u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
    .i_count_input_pin(pin), .i_hw_watchdog_select_pin(strap), .i_ext_reset(ext_rst),
    .i_halt(1'b0), .o_wave_output_pin(wave), .o_irq(irq), .o_system_reset(sysrst));
  twu_pin_model u_pins (.i_clock(i_clock), .i_run(pin_run), .i_wave(wave), .o_pin(pin),
    .o_flips(flips));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // cycles between two ends of count, four per clock/4 enable
  function automatic int per(input int p, input int c);
    return (p + 1) * (c + 1) * TWU_DIV;
  endfunction
  function automatic logic [7:0] rst_val(input logic [2:0] a);
    case (a)
      TWU_OFF_HIGH, TWU_OFF_LOW: return TWU_RST_CNT;
      TWU_OFF_PRESC: return TWU_RST_PRESC;
      TWU_OFF_CTRL: return TWU_RST_CTRL;
      TWU_OFF_WAIT: return TWU_RST_WAIT;
      default: return 8'h00;
    endcase
  endfunction
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; a gap edge keeps each signal to one assignment per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    req <= {a, d, 2'b10};
    @(posedge i_clock);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clock);
    req <= {a, 8'h00, 2'b01};
    @(posedge i_clock);
    req <= '0;
    #1 chk(16'(rdata), 16'(e));
  endtask
  // cycles until irq (s=0) or system reset (s=1), capped at lim
  task automatic wt(input bit s, input int lim, output int c);
    c = 0;
    do begin
      @(negedge i_clock);
      c++;
    end while (!(s ? sysrst === 1'b1 : irq === 1'b1) && c < lim);
  endtask
  // hang guard
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], rst_val(a[2:0]));
    chk(16'(wave), 16'h1);
    repeat (6) begin
      lf = nxt(lf);
      wr(TWU_OFF_PRESC, lf[7:0]);
      rd(TWU_OFF_PRESC, lf[7:0]);
    end
    $display("test registers done");
    // square wave, continuous, clock/4
    wr(TWU_OFF_PRESC, 8'h00);
    wr(TWU_OFF_HIGH, 8'h00);
    wr(TWU_OFF_LOW, 8'h03);
    wr(TWU_OFF_CTRL, 8'h81);
    wt(0, 100, n);
    f0 = flips;
    wt(0, 100, n);
    chk(16'(n), 16'(per(0, 3)));
    chk(16'(flips - f0), 16'h1);
    for (int l = 0; l < 2; l++) begin
      wr(TWU_OFF_CTRL, {6'b100001, l[0], 1'b1});
      wt(0, 100, n);
      chk(16'(wave), 16'(l));
    end
    wr(TWU_OFF_CTRL, 8'h80);
    repeat (2) @(negedge i_clock);
    chk(16'(wave), 16'h1);
    // single mode set while running: stops and clears the run bit
    wr(TWU_OFF_CTRL, 8'hc1);
    wt(0, 100, n);
    rd(TWU_OFF_CTRL, 8'h41);
    wt(0, 40, n);
    chk(16'(n), 16'd40);
    $display("test timer done");
    // event counting on the pin, edges every 8 clocks
    wr(TWU_OFF_LOW, 8'h01);
    pin_run <= 1'b1;
    wr(TWU_OFF_CTRL, 8'h88);
    wt(0, 100, n);
    wt(0, 100, n);
    chk(16'(n), 16'(per(0, 1) * 2));
    // gated: pin high half the time, one enable per pin period
    wr(TWU_OFF_CTRL, 8'h98);
    wt(0, 100, n);
    wt(0, 100, n);
    chk(16'(n), 16'(per(0, 1) * 2));
    // triggerable: armed by earlier edges, then plain clock/4
    wr(TWU_OFF_CTRL, 8'ha8);
    wt(0, 100, n);
    wt(0, 100, n);
    chk(16'(n), 16'(per(0, 1)));
    // retriggerable: edges reload before the count runs out
    wr(TWU_OFF_LOW, 8'h10);
    wr(TWU_OFF_CTRL, 8'hb8);
    wt(0, 20, n);
    wt(0, 100, n);
    chk(16'(n), 16'd100);
    $display("test event done");
    // preload a short constant, then enter watchdog mode
    wr(TWU_OFF_CTRL, 8'h00);
    wr(TWU_OFF_LOW, 8'h20);
    wr(TWU_OFF_CTRL, 8'h80);
    wr(TWU_OFF_WAIT, 8'h3f);
    rd(TWU_OFF_STATUS, 8'h01);
    wr(TWU_OFF_WAIT, 8'h7f);
    rd(TWU_OFF_WAIT, 8'h3f);
    lf = nxt(lf);
    wr(TWU_OFF_PRESC, lf[7:0]);
    rd(TWU_OFF_PRESC, lf[7:0]);
    wr(TWU_OFF_PRESC, 8'h00);
    repeat (3) begin
      wr(TWU_OFF_LOW, TWU_KEY_ARM);
      wr(TWU_OFF_LOW, TWU_KEY_FIRE);
      wt(1, 80, n);
      chk(16'(n), 16'd80);
    end
    // a stray write between the keys must not refresh
    wr(TWU_OFF_LOW, TWU_KEY_ARM);
    wr(TWU_OFF_LOW, 8'h11);
    wr(TWU_OFF_LOW, TWU_KEY_FIRE);
    wt(1, 60, n);
    chk(16'(n < 60), 16'h1);
    $display("test watchdog done");
    // strap low plus external reset forces the watchdog
    @(posedge i_clock);
    i_reset <= 1'b1;
    strap <= 1'b0;
    @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    ext_rst <= 1'b1;
    @(posedge i_clock);
    ext_rst <= 1'b0;
    wr(TWU_OFF_WAIT, 8'h7f);
    rd(TWU_OFF_STATUS, 8'h03);
    $display("test strap done");
    print_verdict();
  end
endmodule // tb
